// file: src/pmcs_consts.svh
`ifndef PMCS_CONSTS_SVH
`define PMCS_CONSTS_SVH

// register byte offsets
`define PMCS_OFS_CTRL 8'h00
`define PMCS_OFS_CTRL2 8'h04
`define PMCS_OFS_TUNE 8'h08
`define PMCS_OFS_STATUS 8'h0c

// control register fields
`define PMCS_CTRL_IDLE_BIT 7
`define PMCS_CTRL_IFS_HI 6
`define PMCS_CTRL_IFS_LO 4
`define PMCS_CTRL_PRI_FLAG_BIT 3
`define PMCS_CTRL_HIGH_FLAG_BIT 2
`define PMCS_CTRL_CS_HI 1
`define PMCS_CTRL_CS_LO 0

// control register 2 fields
`define PMCS_CTRL2_SECONDARY_RUN_MODE_BIT 6
`define PMCS_CTRL2_MED_SEL_BIT 4
`define PMCS_CTRL2_FORCE_ON_BIT 3
`define PMCS_CTRL2_MED_FLAG_BIT 1

// tuning register field
`define PMCS_TUNE_INT_SRC_BIT 7

// status register fields
`define PMCS_STAT_STATE_HI 2
`define PMCS_STAT_STATE_LO 0
`define PMCS_STAT_SRC_HI 5
`define PMCS_STAT_SRC_LO 4

// reset values
`define PMCS_CS_RESET 2'h0
`define PMCS_IFS_RESET 3'h0
`define PMCS_IDLE_RESET 1'h0

// timing
`define PMCS_CLK_MHZ 125
`define PMCS_SWITCH_CYC 3
`define PMCS_INT_SETTLE_NS 1000
`define PMCS_INT_SETTLE_CYC ((`PMCS_INT_SETTLE_NS * `PMCS_CLK_MHZ + 999) / 1000)
`define PMCS_SETTLE_W 16

`endif

// file: src/pmcs_pkg.sv
package pmcs_pkg;

    typedef enum logic [2:0] {
        PMCS_ST_RUN = 3'h0,
        PMCS_ST_SWITCH = 3'h1,
        PMCS_ST_IDLE = 3'h2,
        PMCS_ST_SLEEP = 3'h3,
        PMCS_ST_WAKE = 3'h4
    } pmcs_state_e;

    typedef enum logic [1:0] {
        PMCS_SRC_PRI = 2'h0,
        PMCS_SRC_SEC = 2'h1,
        PMCS_SRC_INT = 2'h2
    } pmcs_src_e;

endpackage : pmcs_pkg

// file: src/pmcs_settle_timer.sv
`timescale 1ns/1ps
`include "pmcs_consts.svh"

module pmcs_settle_timer
    import pmcs_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic enable,
    output logic stable
);

    localparam logic [`PMCS_SETTLE_W-1:0] SETTLE_CYC = `PMCS_SETTLE_W'(`PMCS_INT_SETTLE_CYC);

    logic [`PMCS_SETTLE_W-1:0] count_reg;
    logic [`PMCS_SETTLE_W-1:0] count_next;
    logic stable_next;
    wire done = (count_reg == SETTLE_CYC);

    // dropping the enable restarts the settle interval
    assign count_next = !enable ? '0 : (done ? count_reg : count_reg + `PMCS_SETTLE_W'(1));
    assign stable_next = enable && done;

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            count_reg <= '0;
            stable <= 1'b0;
        end
        else if (clk_en)
        begin
            count_reg <= count_next;
            stable <= stable_next;
        end
    end

endmodule : pmcs_settle_timer

// file: src/pmcs_power_mode_clock_select.sv
// Design decisions made here: the address map and the APB slave port.
`timescale 1ns/1ps
`include "pmcs_consts.svh"

// Summary of operation
// - clock-select write switches source when running
// - sleep with idle-select 0 stops clocks
// - sleep with idle-select 1 stops cpu only
// - idle-select sampled at sleep instruction
// - run modes clock cpu and peripherals
// - reset starts in primary run mode
// - select 01 gives secondary run, flags follow
// - secondary run waits for enable and ready
// - secondary to primary waits for primary ready
// - upper select bit gives internal run
// - internal frequency select changes take effect immediately
// - all-clear frequency select keeps output disabled while the tuning source-select bit is clear
// - stability flag set after settle interval
// - already stable output keeps flag set
// - internal to primary waits, then swaps flags
// - low-frequency source kept for watchdog/monitor
// - stability flags decoded from select bits
// - internal run entry/exit has switch delay
// - transition completes in few oscillator periods

module pmcs_power_mode_clock_select
    import pmcs_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sleep_exec,
    input wire logic wake_event,
    input wire logic primary_osc_ready,
    input wire logic secondary_osc_ready,
    input wire logic timer_secondary_osc_enable,
    input wire logic watchdog_en,
    input wire logic fscm_en,
    output logic [1:0] sys_clk_src,
    output logic cpu_clk_en,
    output logic periph_clk_en,
    output logic primary_osc_en,
    output logic secondary_osc_en,
    output logic low_freq_osc_en,
    output logic internal_out_en,
    output logic [2:0] internal_freq_sel,
    output logic medium_osc_sel_out,
    output logic primary_ready_flag,
    output logic secondary_running_flag,
    output logic high_internal_stable_flag,
    output logic medium_internal_stable_flag,
    output logic [2:0] power_mode
);

    // target source encoded by the clock-select field
    function automatic pmcs_src_e src_of(input logic [1:0] cs);
        if (cs[1])
            return PMCS_SRC_INT;
        else if (cs[0])
            return PMCS_SRC_SEC;
        else
            return PMCS_SRC_PRI;
    endfunction : src_of

    localparam logic [2:0] SWITCH_CYC = 3'(`PMCS_SWITCH_CYC);

    // software-owned control bits
    logic idle_select_reg;
    logic [2:0] internal_freq_select_reg;
    logic [1:0] clock_select_reg;
    logic medium_osc_select_reg;
    logic secondary_osc_force_on_reg;
    logic internal_source_select_reg;

    // mode and source state
    pmcs_state_e state_reg;
    pmcs_state_e state_next;
    pmcs_src_e cur_src_reg;
    pmcs_src_e cur_src_next;
    pmcs_src_e pend_src_reg;
    pmcs_src_e pend_src_next;
    logic [2:0] switch_cnt_reg;
    logic [2:0] switch_cnt_next;
    logic pri_flag_reg;
    logic pri_flag_next;
    logic sec_flag_reg;
    logic sec_flag_next;
    logic stab_clr_reg;
    logic stab_clr_next;
    logic [31:0] rdata_next;

    // bus decode
    wire wr_en = psel && penable && pwrite;
    wire rd_setup = psel && !penable && !pwrite;
    wire hit_ctrl = (paddr == `PMCS_OFS_CTRL);
    wire hit_ctrl2 = (paddr == `PMCS_OFS_CTRL2);
    wire hit_tune = (paddr == `PMCS_OFS_TUNE);
    wire hit_status = (paddr == `PMCS_OFS_STATUS);
    wire hit_any = hit_ctrl || hit_ctrl2 || hit_tune || hit_status;
    wire wr_ctrl = wr_en && hit_ctrl;
    wire wr_ctrl2 = wr_en && hit_ctrl2;
    wire wr_tune = wr_en && hit_tune;

    // zero-wait slave; unmapped addresses answer with an error
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit_any;

    wire sec_enabled = secondary_osc_force_on_reg || timer_secondary_osc_enable;
    wire pmcs_src_e tgt_src = src_of(clock_select_reg);

    // target usable only when its source runs
    wire tgt_ok = (tgt_src == PMCS_SRC_INT) ||
                  ((tgt_src == PMCS_SRC_PRI) && primary_osc_ready) ||
                  ((tgt_src == PMCS_SRC_SEC) && sec_enabled && secondary_osc_ready);
    wire cur_ok = (cur_src_reg == PMCS_SRC_INT) ||
                  ((cur_src_reg == PMCS_SRC_PRI) && primary_osc_ready) ||
                  ((cur_src_reg == PMCS_SRC_SEC) && secondary_osc_ready);
    wire want_switch = (tgt_src != cur_src_reg) && tgt_ok;
    wire switch_done = (state_reg == PMCS_ST_SWITCH) && (switch_cnt_reg == 3'h1);

    // internal output enabled by any non-clear select
    wire int_enable = (internal_freq_select_reg != 3'h0) || internal_source_select_reg;
    wire int_stable;

    // sleep drops the output, so the flags clear and settle again on wake
    // settle interval before the stability flag
    pmcs_settle_timer u_settle
    (
        .clk(clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .enable(internal_out_en),
        .stable(int_stable)
    );

    // mode sequencing
    always_comb
    begin
        state_next = state_reg;
        cur_src_next = cur_src_reg;
        pend_src_next = pend_src_reg;
        switch_cnt_next = switch_cnt_reg;
        unique case (state_reg)
            PMCS_ST_RUN, PMCS_ST_SWITCH:
            begin
                // idle-select read in the sleep cycle itself
                if (sleep_exec)
                begin
                    state_next = idle_select_reg ? PMCS_ST_IDLE : PMCS_ST_SLEEP;
                end
                else if (state_reg == PMCS_ST_RUN)
                begin
                    // every source change, internal included, pays the delay
                    if (want_switch)
                    begin
                        state_next = PMCS_ST_SWITCH;
                        pend_src_next = tgt_src;
                        switch_cnt_next = SWITCH_CYC;
                    end
                end
                else if (switch_done)
                begin
                    // old clock held until the delay ends, then one clean swap
                    // swap lands a fixed few periods after ready
                    state_next = PMCS_ST_RUN;
                    cur_src_next = pend_src_reg;
                    switch_cnt_next = 3'h0;
                end
                else
                begin
                    switch_cnt_next = switch_cnt_reg - 3'h1;
                end
            end
            PMCS_ST_IDLE:
            begin
                if (wake_event)
                    state_next = PMCS_ST_RUN;
            end
            PMCS_ST_SLEEP:
            begin
                if (wake_event)
                    state_next = PMCS_ST_WAKE;
            end
            PMCS_ST_WAKE:
            begin
                // clocks stay gated until the selected source is back
                if (cur_ok)
                    state_next = PMCS_ST_RUN;
            end
            default:
            begin
                state_next = PMCS_ST_RUN;
            end
        endcase
    end

    // sleep drops both ready flags; on wake only the primary flag waits for its source again
    // flags follow the source actually in use
    assign pri_flag_next = (cur_src_next == PMCS_SRC_PRI) && primary_osc_ready && (state_next != PMCS_ST_SLEEP);
    assign sec_flag_next = (cur_src_next == PMCS_SRC_SEC) && (state_next != PMCS_ST_SLEEP);

    // a switch end beats a write in the same cycle, so the clear is not lost
    // leaving internal run clears stability indication
    // no clear while internal run stays selected
    assign stab_clr_next = (switch_done && (cur_src_reg == PMCS_SRC_INT) && (pend_src_reg != PMCS_SRC_INT)) ? 1'b1 :
                           ((wr_ctrl || wr_ctrl2 || wr_tune || (cur_src_reg == PMCS_SRC_INT)) ? 1'b0 : stab_clr_reg);

    // read data captured in the setup cycle, shown in the access cycle
    always_comb
    begin
        rdata_next = 32'h0;
        if (hit_ctrl)
        begin
            rdata_next[`PMCS_CTRL_IDLE_BIT] = idle_select_reg;
            rdata_next[`PMCS_CTRL_IFS_HI:`PMCS_CTRL_IFS_LO] = internal_freq_select_reg;
            rdata_next[`PMCS_CTRL_PRI_FLAG_BIT] = pri_flag_reg;
            rdata_next[`PMCS_CTRL_HIGH_FLAG_BIT] = high_internal_stable_flag;
            rdata_next[`PMCS_CTRL_CS_HI:`PMCS_CTRL_CS_LO] = clock_select_reg;
        end
        else if (hit_ctrl2)
        begin
            rdata_next[`PMCS_CTRL2_SECONDARY_RUN_MODE_BIT] = sec_flag_reg;
            rdata_next[`PMCS_CTRL2_MED_SEL_BIT] = medium_osc_select_reg;
            rdata_next[`PMCS_CTRL2_FORCE_ON_BIT] = secondary_osc_force_on_reg;
            rdata_next[`PMCS_CTRL2_MED_FLAG_BIT] = medium_internal_stable_flag;
        end
        else if (hit_tune)
        begin
            rdata_next[`PMCS_TUNE_INT_SRC_BIT] = internal_source_select_reg;
        end
        else if (hit_status)
        begin
            rdata_next[`PMCS_STAT_STATE_HI:`PMCS_STAT_STATE_LO] = state_reg;
            rdata_next[`PMCS_STAT_SRC_HI:`PMCS_STAT_SRC_LO] = cur_src_reg;
        end
    end

    // software registers; flags and mode are read-only
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            idle_select_reg <= `PMCS_IDLE_RESET;
            internal_freq_select_reg <= `PMCS_IFS_RESET;
            clock_select_reg <= `PMCS_CS_RESET;
            medium_osc_select_reg <= 1'b0;
            secondary_osc_force_on_reg <= 1'b0;
            internal_source_select_reg <= 1'b0;
            prdata <= 32'h0;
        end
        else if (clk_en)
        begin
            if (wr_ctrl)
            begin
                idle_select_reg <= pwdata[`PMCS_CTRL_IDLE_BIT];
                internal_freq_select_reg <= pwdata[`PMCS_CTRL_IFS_HI:`PMCS_CTRL_IFS_LO];
                clock_select_reg <= pwdata[`PMCS_CTRL_CS_HI:`PMCS_CTRL_CS_LO];
            end
            if (wr_ctrl2)
            begin
                medium_osc_select_reg <= pwdata[`PMCS_CTRL2_MED_SEL_BIT];
                secondary_osc_force_on_reg <= pwdata[`PMCS_CTRL2_FORCE_ON_BIT];
            end
            if (wr_tune)
                internal_source_select_reg <= pwdata[`PMCS_TUNE_INT_SRC_BIT];
            if (rd_setup)
                prdata <= rdata_next;
        end
    end

    // mode state
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            state_reg <= PMCS_ST_RUN;
            cur_src_reg <= PMCS_SRC_PRI;
            pend_src_reg <= PMCS_SRC_PRI;
            switch_cnt_reg <= 3'h0;
            pri_flag_reg <= 1'b0;
            sec_flag_reg <= 1'b0;
            stab_clr_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            state_reg <= state_next;
            cur_src_reg <= cur_src_next;
            pend_src_reg <= pend_src_next;
            switch_cnt_reg <= switch_cnt_next;
            pri_flag_reg <= pri_flag_next;
            sec_flag_reg <= sec_flag_next;
            stab_clr_reg <= stab_clr_next;
        end
    end

    // source select only moves at the end of a switch
    assign sys_clk_src = cur_src_reg;

    // run modes clock both cpu and peripherals
    assign cpu_clk_en = (state_reg == PMCS_ST_RUN) || (state_reg == PMCS_ST_SWITCH);
    assign periph_clk_en = cpu_clk_en || (state_reg == PMCS_ST_IDLE);

    // primary stops once another source has taken over
    assign primary_osc_en = (state_reg != PMCS_ST_SLEEP) &&
                            ((cur_src_reg == PMCS_SRC_PRI) || (tgt_src == PMCS_SRC_PRI));
    // secondary keeps running through sleep when enabled
    assign secondary_osc_en = sec_enabled;
    // watchdog or monitor keeps the low-frequency source alive
    assign low_freq_osc_en = watchdog_en || fscm_en ||
                             ((state_reg != PMCS_ST_SLEEP) && (cur_src_reg == PMCS_SRC_INT));
    // output stays off when all selects are clear
    assign internal_out_en = int_enable && (state_reg != PMCS_ST_SLEEP);
    // frequency select drives the postscaler directly
    assign internal_freq_sel = internal_freq_select_reg;
    assign medium_osc_sel_out = medium_osc_select_reg;

    assign primary_ready_flag = pri_flag_reg;
    assign secondary_running_flag = sec_flag_reg;

    // medium-select picks which flag reports stability
    assign high_internal_stable_flag = int_stable && !medium_osc_select_reg && !stab_clr_reg;
    assign medium_internal_stable_flag = int_stable && medium_osc_select_reg && !stab_clr_reg;

    assign power_mode = state_reg;

endmodule : pmcs_power_mode_clock_select

// file: test/pmcs_monitor.sv
`timescale 1ns/1ps

module pmcs_monitor
(
    input logic clk,
    input logic reset_n,
    input logic clk_en,
    input logic psel,
    input logic penable,
    input logic [7:0] paddr,
    input logic pready,
    input logic pslverr,
    input logic sleep_exec,
    input logic primary_osc_ready,
    input logic secondary_osc_ready,
    input logic watchdog_en,
    input logic fscm_en,
    input logic [1:0] sys_clk_src,
    input logic cpu_clk_en,
    input logic periph_clk_en,
    input logic internal_out_en,
    input logic medium_osc_sel_out,
    input logic low_freq_osc_en,
    input logic primary_ready_flag,
    input logic secondary_running_flag,
    input logic high_internal_stable_flag,
    input logic medium_internal_stable_flag,
    input logic [2:0] power_mode
);
default clocking @(posedge clk);
endclocking
default disable iff (!reset_n);

a_reset_home: assert property (disable iff (1'h0) !reset_n && clk_en |=>
    sys_clk_src == 2'h0 && power_mode == 3'h0)
    else $error("reset did not return to primary run");
a_run_clocks: assert property (power_mode inside {3'h0, 3'h1} |-> cpu_clk_en && periph_clk_en)
    else $error("run mode without both clocks");
a_sleep_off: assert property (power_mode == 3'h3 |-> !cpu_clk_en && !periph_clk_en)
    else $error("clock running in sleep");
a_idle_clocks: assert property (power_mode == 3'h2 |-> !cpu_clk_en && periph_clk_en)
    else $error("idle clock gating wrong");
a_sleep_taken: assert property (power_mode inside {3'h0, 3'h1} && sleep_exec && clk_en |=>
    power_mode inside {3'h2, 3'h3})
    else $error("sleep instruction not taken");
a_sec_flags: assert property ($rose(sys_clk_src == 2'h1) |-> secondary_running_flag && !primary_ready_flag)
    else $error("flags wrong on secondary entry");
a_sec_ready: assert property ($rose(sys_clk_src == 2'h1) |-> $past(secondary_osc_ready))
    else $error("secondary taken before ready");
a_pri_ready: assert property (reset_n && $past(reset_n) && $rose(sys_clk_src == 2'h0) |->
    $past(primary_osc_ready) && primary_ready_flag)
    else $error("primary taken before ready");
a_int_flag: assert property (sys_clk_src == 2'h2 |-> !primary_ready_flag)
    else $error("primary flag set in internal run");
a_lf_kept: assert property (watchdog_en || fscm_en |-> low_freq_osc_en)
    else $error("low frequency source stopped");
a_flag_decode: assert property (high_internal_stable_flag || medium_internal_stable_flag |->
    high_internal_stable_flag != medium_osc_sel_out && medium_internal_stable_flag == medium_osc_sel_out &&
    $past(internal_out_en))
    else $error("stability flag decode wrong");
a_off_clear: assert property (!internal_out_en ##1 !internal_out_en |->
    !high_internal_stable_flag && !medium_internal_stable_flag)
    else $error("stability flag with output off");
a_settle_wait: assert property ($rose(internal_out_en) |->
    (!high_internal_stable_flag && !medium_internal_stable_flag)[*8])
    else $error("stability flag before settling");
a_switch_hold: assert property ($rose(power_mode == 3'h1) |-> $stable(sys_clk_src)[*3] ##1 power_mode != 3'h1)
    else $error("switch delay wrong");
a_bus_error: assert property (psel && penable && paddr > 8'h0c |-> pready && pslverr)
    else $error("unmapped access not refused");

c_idle: cover property (power_mode == 3'h2);
c_sleep: cover property (power_mode == 3'h3);
c_sec: cover property (sys_clk_src == 2'h1);
c_int_stable: cover property (sys_clk_src == 2'h2 && high_internal_stable_flag);
endmodule : pmcs_monitor

bind pmcs_power_mode_clock_select pmcs_monitor u_mon
(
    .clk, .reset_n, .clk_en, .psel, .penable, .paddr, .pready, .pslverr, .sleep_exec, .primary_osc_ready,
    .secondary_osc_ready, .watchdog_en, .fscm_en, .sys_clk_src, .cpu_clk_en, .periph_clk_en, .internal_out_en,
    .medium_osc_sel_out, .low_freq_osc_en, .primary_ready_flag, .secondary_running_flag,
    .high_internal_stable_flag, .medium_internal_stable_flag, .power_mode
);

// file: test/pmcs_osc_model.sv
`timescale 1ns/1ps

module pmcs_osc_model
(
    input logic clk,
    input logic primary_osc_en,
    input logic secondary_osc_en,
    input logic [7:0] pri_delay,
    input logic [7:0] sec_delay,
    output logic primary_osc_ready = 1'h0,
    output logic secondary_osc_ready = 1'h0
);
int pri_cnt = 0;
int sec_cnt = 0;

// ready is registered to keep the enable-to-ready path free of loops
always @(posedge clk)
begin
    pri_cnt <= primary_osc_en ? pri_cnt + 1 : 0;
    sec_cnt <= secondary_osc_en ? sec_cnt + 1 : 0;
    primary_osc_ready <= primary_osc_en && pri_cnt >= pri_delay;
    secondary_osc_ready <= secondary_osc_en && sec_cnt >= sec_delay;
end
endmodule : pmcs_osc_model

// file: test/testbench.sv
`timescale 1ns/1ps
`include "pmcs_consts.svh"

module testbench
    import pmcs_pkg::*;
;
logic clk = 1'h0;
logic reset_n = 1'h0;
logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, sleep_exec = 1'h0, wake_event = 1'h0;
logic tmr_en = 1'h0, wdt_en = 1'h0, fscm_en = 1'h0, clk_en = 1'h1, e, m_med, m_idle;
logic [7:0] paddr = 8'h0, pri_dly = 8'h02, sec_dly = 8'h02;
logic [31:0] pwdata = 32'h0, q;
logic [2:0] m_ifs;
logic [1:0] m_cs, t_src;
wire [31:0] prdata;
wire pready, pslverr, pri_rdy, sec_rdy, pri_en, sec_en, lf_en, io_en, med_o;
wire cpu_en, per_en, pflag, sflag, hflag, mflag;
wire [1:0] src;
wire [2:0] ifs, mode;
int err_count = 0, num_checks = 0, r;

pmcs_power_mode_clock_select uut
(
    .clk(clk), .reset_n(reset_n), .clk_en(clk_en), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleep_exec(sleep_exec), .wake_event(wake_event), .primary_osc_ready(pri_rdy),
    .secondary_osc_ready(sec_rdy), .timer_secondary_osc_enable(tmr_en), .watchdog_en(wdt_en),
    .fscm_en(fscm_en), .sys_clk_src(src), .cpu_clk_en(cpu_en), .periph_clk_en(per_en),
    .primary_osc_en(pri_en), .secondary_osc_en(sec_en), .low_freq_osc_en(lf_en), .internal_out_en(io_en),
    .internal_freq_sel(ifs), .medium_osc_sel_out(med_o), .primary_ready_flag(pflag),
    .secondary_running_flag(sflag), .high_internal_stable_flag(hflag),
    .medium_internal_stable_flag(mflag), .power_mode(mode)
);

pmcs_osc_model u_osc
(
    .clk(clk), .primary_osc_en(pri_en), .secondary_osc_en(sec_en), .pri_delay(pri_dly),
    .sec_delay(sec_dly), .primary_osc_ready(pri_rdy), .secondary_osc_ready(sec_rdy)
);

initial
begin
    forever #4 clk = ~clk;
end

task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
        $display("All checks passed");
    else
        $display("Checks failed");
    $finish;
endtask : close_out

task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
        err_count++;
        $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
endtask : check

task automatic tmo;
    err_count++;
    $display("unexpected wait timeout");
    close_out();
endtask : tmo

task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1 && n < 50)
    begin
        @(posedge clk);
        n++;
    end
    if (n >= 50)
        tmo();
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
endtask : apb

task automatic wctrl(input logic i, input logic [2:0] f, input logic [1:0] c);
    m_idle = i;
    m_ifs = f;
    m_cs = c;
    apb(1'h1, `PMCS_OFS_CTRL, {24'h0, i, f, 2'h0, c});
endtask : wctrl

task automatic pulse(input logic wk);
    @(posedge clk);
    if (wk)
        wake_event <= 1'h1;
    else
        sleep_exec <= 1'h1;
    @(posedge clk);
    wake_event <= 1'h0;
    sleep_exec <= 1'h0;
endtask : pulse

function automatic logic seen_ok(input int k);
    case (k)
        0: return pflag === 1'h1;
        1: return (hflag | mflag) === 1'h1;
        default: return src === t_src && mode === 3'h0;
    endcase
endfunction : seen_ok

task automatic wait_on(input int k);
    int n;
    for (n = 0; n < 400 && !seen_ok(k); n++)
        @(negedge clk);
    if (n >= 400)
        tmo();
endtask : wait_on

function automatic logic [31:0] ctrl_exp(input logic pf, input logic hf);
    return {24'h0, m_idle, m_ifs, pf, hf, m_cs};
endfunction : ctrl_exp

initial
begin
    r = $urandom(96659);
    m_idle = 1'h0;
    m_ifs = 3'h0;
    m_cs = 2'h0;
    t_src = 2'h0;
    repeat (6) @(posedge clk);
    reset_n <= 1'h1;
    wait_on(0);
    check("source", {mode, src}, 5'h0);
    check("run clocks", {cpu_en, per_en}, 2'h3);
    apb(1'h0, `PMCS_OFS_CTRL, 32'h0);
    check("ctrl", q, ctrl_exp(1'h1, 1'h0));
    apb(1'h0, 8'h10, 32'h0);
    check("unmapped error", {31'h0, e}, 32'h1);
    check("unmapped data", q, 32'h0);
    sec_dly <= 8'($urandom_range(20, 5));
    wctrl(1'h0, 3'h0, 2'h1);
    repeat (20) @(negedge clk);
    check("held source", src, 2'h0);
    r = $urandom;
    if (r[0])
    begin
        @(posedge clk);
        tmr_en <= 1'h1;
    end
    else
        apb(1'h1, `PMCS_OFS_CTRL2, 32'h8);
    t_src = 2'h1;
    wait_on(2);
    check("sec flags", {sflag, pflag, pri_en, sec_en}, 4'h9);
    wctrl(1'h1, 3'h0, 2'h1);
    pulse(1'h0);
    wctrl(1'h0, 3'h0, 2'h1);
    @(negedge clk);
    check("idle", {mode, cpu_en, per_en, src}, 7'h25);
    pulse(1'h1);
    wait_on(2);
    pri_dly <= 8'($urandom_range(30, 5));
    wctrl(1'h0, 3'h0, 2'h0);
    repeat (3) @(negedge clk);
    check("sec kept", src, 2'h1);
    t_src = 2'h0;
    wait_on(2);
    check("pri flags", {sflag, pflag}, 2'h1);
    // frozen write must not land
    @(posedge clk);
    clk_en <= 1'h0;
    apb(1'h1, `PMCS_OFS_CTRL, 32'h2);
    @(posedge clk);
    clk_en <= 1'h1;
    apb(1'h0, `PMCS_OFS_CTRL, 32'h0);
    check("frozen", q, ctrl_exp(1'h1, 1'h0));
    m_med = 1'($urandom);
    apb(1'h1, `PMCS_OFS_CTRL2, {27'h0, m_med, 4'h0});
    r = $urandom;
    wctrl(1'h0, 3'($urandom_range(2, 1)), {1'h1, r[0]});
    @(negedge clk);
    check("freq", ifs, m_ifs);
    t_src = 2'h2;
    wait_on(2);
    check("int flags", {pflag, pri_en}, 2'h0);
    wait_on(1);
    check("stable", {hflag, mflag}, {~m_med, m_med});
    wctrl(1'h0, 3'h3 - m_ifs, m_cs);
    @(negedge clk);
    check("freq", ifs, m_ifs);
    check("stable kept", {hflag, mflag}, {~m_med, m_med});
    apb(1'h0, `PMCS_OFS_CTRL, 32'h0);
    check("ctrl", q, ctrl_exp(1'h0, ~m_med));
    apb(1'h1, `PMCS_OFS_CTRL2, 32'h10);
    m_med = 1'h1;
    wctrl(1'h0, 3'h0, m_cs);
    repeat (2) @(negedge clk);
    check("all clear", {io_en, hflag, mflag}, 3'h0);
    apb(1'h1, `PMCS_OFS_TUNE, 32'h80);
    wait_on(1);
    check("int source", {hflag, mflag}, 2'h1);
    pulse(1'h0);
    @(negedge clk);
    check("sleep", {mode, cpu_en, per_en}, 5'hc);
    pulse(1'h1);
    wait_on(2);
    @(posedge clk);
    wdt_en <= 1'h1;
    fscm_en <= 1'($urandom);
    wctrl(1'h0, 3'h0, 2'h0);
    t_src = 2'h0;
    wait_on(2);
    check("back flags", {hflag, mflag, pflag, lf_en}, 4'h3);
    apb(1'h0, `PMCS_OFS_CTRL, 32'h0);
    check("ctrl", q, ctrl_exp(1'h1, 1'h0));
    close_out();
end
endmodule : testbench
